// ### rtl/ptq_defines.svh
// constants for the pass-through command queue
`ifndef PTQ_DEFINES_SVH
`define PTQ_DEFINES_SVH
`define PTQ_BLK_WORDS      250
`define PTQ_LAST_WORD      249
`define PTQ_ACK_LAST_WORD  247
`define PTQ_ID_DOUT        16'h2708
`define PTQ_ID_PULSE       16'h2709
`define PTQ_ID_TRAIN       16'h270a
`define PTQ_ID_TIME        16'h270b
`define PTQ_FN_DOUT        8'h16
`define PTQ_FN_PULSE       8'h19
`define PTQ_FN_TRAIN       8'h1a
`define PTQ_FN_TIME        8'h20
`define PTQ_PULSE_POINT_W  18
`define PTQ_ARG_WORDS      17
`endif

// ### rtl/ptq_pkg.sv
// types for the pass-through command queue
package ptq_pkg;
  typedef struct packed {
    logic [7:0]       func;
    logic [16:0][15:0] args;
  } ptq_cmd_s;
  typedef enum logic [2:0] {
    PTQ_IDLE = 3'b001,
    PTQ_SEND = 3'b010,
    PTQ_WAIT = 3'b100
  } ptq_state_e;
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } ptq_db_wr_s;
endpackage

// ### rtl/ptq_pass_through_queue.sv
// pass-through command queue between serial slave port and host controller
`timescale 1ns/10ps
`include "ptq_defines.svh"
module ptq_pass_through_queue #(
  parameter int DEPTH = 4
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              cmd_valid_in,
  input  wire ptq_pkg::ptq_cmd_s cmd_in,
  output logic                   cmd_ready_out,
  input  wire logic              mst_wr_valid_in,
  input  wire ptq_pkg::ptq_db_wr_s mst_wr_in,
  input  wire logic              mst_rd_valid_in,
  input  wire logic [15:0]       mst_rd_addr_in,
  input  wire logic [15:0]       db_rd_data_in,
  output logic                   mst_rd_valid_out,
  output logic [15:0]            mst_rd_data_out,
  output ptq_pkg::ptq_db_wr_s    db_wr_out,
  output logic [15:0]            db_rd_addr_out,
  input  wire logic              hw_handshake_enable_in,
  input  wire logic              clear_to_send_in,
  output logic                   request_to_send_out,
  input  wire logic              blk_rd_req_in,
  input  wire logic [7:0]        blk_word_idx_in,
  output logic                   blk_valid_out,
  output logic [15:0]            blk_word_out,
  input  wire logic              ack_valid_in,
  input  wire logic [15:0]       ack_word0_in,
  output logic                   ack_taken_out
);
  localparam int AW = $clog2(DEPTH);

  logic                   rst_meta;
  logic                   rst_n;
  ptq_pkg::ptq_cmd_s      mem [DEPTH];
  logic [AW:0]            rd_ptr;
  logic [AW:0]            wr_ptr;
  logic [AW:0]            next_rd_ptr;
  logic [AW:0]            next_wr_ptr;
  logic                   empty;
  logic                   full;
  logic                   push;
  logic                   pop;
  logic                   cmd_ok;
  ptq_pkg::ptq_cmd_s      head;
  logic [15:0]            head_id;
  logic [15:0]            next_blk_word;
  logic                   next_rd_valid;
  logic [15:0]            next_rd_data;
  ptq_pkg::ptq_db_wr_s    next_db_wr;
  logic                   next_ack_taken;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // only the four pass-through functions are queued
  always_comb
  begin
    cmd_ok = (cmd_in.func == `PTQ_FN_DOUT) || (cmd_in.func == `PTQ_FN_PULSE) ||
             (cmd_in.func == `PTQ_FN_TRAIN) || (cmd_in.func == `PTQ_FN_TIME);
  end

  assign empty         = (rd_ptr == wr_ptr);
  assign full          = (rd_ptr[AW-1:0] == wr_ptr[AW-1:0]) && (rd_ptr[AW] != wr_ptr[AW]);
  assign cmd_ready_out = !full;
  assign push          = cmd_valid_in && !full && cmd_ok;
  assign head          = mem[rd_ptr[AW-1:0]];
  assign blk_valid_out = !empty;

  // block id from function code
  always_comb
  begin
    case (head.func)
      `PTQ_FN_DOUT:  head_id = `PTQ_ID_DOUT;
      `PTQ_FN_PULSE: head_id = `PTQ_ID_PULSE;
      `PTQ_FN_TRAIN: head_id = `PTQ_ID_TRAIN;
      `PTQ_FN_TIME:  head_id = `PTQ_ID_TIME;
      default:       head_id = 16'h0000;
    endcase
  end

  // acknowledge matching head pops it; a mismatch leaves head presented
  assign pop = ack_valid_in && !empty && (ack_word0_in == head_id);

  always_comb
  begin
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_ack_taken = pop;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      ack_taken_out <= 1'b0;
    end
    else
    begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      ack_taken_out <= next_ack_taken;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= cmd_in;
    end
  end

  // word of the head block, one cycle after request
  always_comb
  begin
    next_blk_word = 16'h0000;
    if (blk_rd_req_in && !empty)
    begin
      if (blk_word_idx_in == 8'h01 || blk_word_idx_in == 8'(`PTQ_LAST_WORD))
      begin
        next_blk_word = head_id;
      end
      else if (blk_word_idx_in >= 8'h02 && blk_word_idx_in <= 8'h12)
      begin
        // argument slots fill words 2..18 in order, unused slots sent as zero
        next_blk_word = head.args[5'(blk_word_idx_in - 8'h02)];
        if (head.func == `PTQ_FN_DOUT && blk_word_idx_in > 8'h05)
        begin
          next_blk_word = 16'h0000;
        end
        if (head.func == `PTQ_FN_TRAIN && blk_word_idx_in > 8'h06)
        begin
          next_blk_word = 16'h0000;
        end
        if (head.func == `PTQ_FN_TIME && blk_word_idx_in > 8'h07)
        begin
          next_blk_word = 16'h0000;
        end
      end
    end
  end

  // slave port: writes go to database, reads answered from database
  always_comb
  begin
    next_db_wr    = mst_wr_in;
    next_db_wr.write = mst_wr_valid_in;
    next_rd_valid = mst_rd_valid_in &&
                    (!hw_handshake_enable_in || clear_to_send_in);
    next_rd_data  = db_rd_data_in;
  end

  assign db_rd_addr_out      = mst_rd_addr_in;
  // with handshake on, request-to-send follows pending reply, sent once clear
  assign request_to_send_out = hw_handshake_enable_in ? mst_rd_valid_in : 1'b0;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blk_word_out     <= 16'h0000;
      mst_rd_valid_out <= 1'b0;
      mst_rd_data_out  <= 16'h0000;
      db_wr_out        <= '0;
    end
    else
    begin
      blk_word_out     <= next_blk_word;
      mst_rd_valid_out <= next_rd_valid;
      mst_rd_data_out  <= next_rd_data;
      db_wr_out        <= next_db_wr;
    end
  end

  // matching acknowledgement for the presented head block
  sequence s_head_acked;
    ack_valid_in && !empty && (ack_word0_in == head_id);
  endsequence

  a_pop_advances: assert property (@(posedge clk_in) disable iff (!rst_n)
    pop |=> rd_ptr == $past(rd_ptr) + 1'b1) else $error("ack did not pop");
  a_id_word: assert property (@(posedge clk_in) disable iff (!rst_n)
    blk_rd_req_in && !empty && blk_word_idx_in == 8'h01 && !pop
    |=> blk_word_out == $past(head_id)) else $error("bad id word");
  a_word_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    blk_rd_req_in && blk_word_idx_in == 8'h00 |=> blk_word_out == 16'h0000)
    else $error("word 0 not zero");
  a_mismatch_holds: assert property (@(posedge clk_in) disable iff (!rst_n)
    ack_valid_in && ack_word0_in != head_id && !push |=> rd_ptr == $past(rd_ptr))
    else $error("mismatched ack popped");
  a_wr_forward: assert property (@(posedge clk_in) disable iff (!rst_n)
    mst_wr_valid_in |=> db_wr_out.write && db_wr_out.addr == $past(mst_wr_in.addr))
    else $error("write not forwarded");
  a_cts_block: assert property (@(posedge clk_in) disable iff (!rst_n)
    hw_handshake_enable_in && !clear_to_send_in |=> !mst_rd_valid_out)
    else $error("sent without cts");
  a_push_grows: assert property (@(posedge clk_in) disable iff (!rst_n)
    push && !pop |=> wr_ptr == $past(wr_ptr) + 1'b1) else $error("push lost");
  a_rd_answer: assert property (@(posedge clk_in) disable iff (!rst_n)
    mst_rd_valid_in && !hw_handshake_enable_in |=> mst_rd_valid_out)
    else $error("read not answered");
  a_ack_pulse: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_head_acked |=> ack_taken_out) else $error("ack not reported");
  a_spare_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    blk_rd_req_in && blk_word_idx_in > 8'h12 && blk_word_idx_in != 8'hf9
    |=> blk_word_out == 16'h0000) else $error("spare word not zero");
endmodule

// ### testbench/ptq_host_model.sv
// host controller model that reads and acknowledges pass-through blocks
`timescale 1ns/10ps
module ptq_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] blk_word_in,
  input  wire logic        ack_taken_in,
  output logic             blk_rd_req_out,
  output logic [7:0]       blk_word_idx_out,
  output logic             ack_valid_out,
  output logic [15:0]      ack_word0_out
);
  initial
  begin
    blk_rd_req_out = 1'b0;
    blk_word_idx_out = 8'h00;
    ack_valid_out = 1'b0;
    ack_word0_out = 16'h0000;
  end
  // fetch one word of the head block
  task automatic rd(input logic [7:0] idx, output logic [15:0] w);
    @(posedge clk_in);
    #1;
    blk_rd_req_out = 1'b1;
    blk_word_idx_out = idx;
    @(posedge clk_in);
    #1;
    w = blk_word_in;
    blk_rd_req_out = 1'b0;
    blk_word_idx_out = ~idx;
  endtask
  // accept the block and answer with its id in word 0
  task automatic ack(input logic [15:0] id, output logic taken);
    @(posedge clk_in);
    #1;
    ack_valid_out = 1'b1;
    ack_word0_out = id;
    @(posedge clk_in);
    #1;
    taken = ack_taken_in;
    ack_valid_out = 1'b0;
    ack_word0_out = ~id;
  endtask
endmodule

// ### testbench/tb_pass_through_queue.sv
// self-checking bench for the pass-through command queue
`timescale 1ns/10ps
`include "ptq_defines.svh"
module tb_pass_through_queue;
  logic                clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic                cmd_valid_in = 1'b0;
  ptq_pkg::ptq_cmd_s   cmd_in = '0;
  logic                mst_wr_valid_in = 1'b0;
  ptq_pkg::ptq_db_wr_s mst_wr_in = '0;
  ptq_pkg::ptq_db_wr_s db_wr_out;
  logic                mst_rd_valid_in = 1'b0;
  logic [15:0]         mst_rd_addr_in = '0;
  logic [15:0]         db_rd_data_in = '0;
  logic                hw_handshake_enable_in = 1'b0;
  logic                clear_to_send_in = 1'b0;
  logic                cmd_ready_out, mst_rd_valid_out, request_to_send_out;
  logic                blk_valid_out, ack_taken_out, blk_rd_req_in, ack_valid_in, t;
  logic [15:0]         mst_rd_data_out, db_rd_addr_out, blk_word_out, ack_word0_in, w;
  logic [7:0]          blk_word_idx_in;
  logic [7:0]          fn_tab [4] = '{`PTQ_FN_DOUT, `PTQ_FN_PULSE, `PTQ_FN_TRAIN, `PTQ_FN_TIME};
  int                  last_tab [4] = '{5, 18, 6, 7};
  int                  n_fail = 0;
  int                  checks_done = 0;
  always #4 clk_in = ~clk_in;
  ptq_pass_through_queue #(.DEPTH(4)) i_ptq_pass_through_queue (.clk_in, .rst_n_in,
    .cmd_valid_in, .cmd_in, .cmd_ready_out, .mst_wr_valid_in, .mst_wr_in, .mst_rd_valid_in,
    .mst_rd_addr_in, .db_rd_data_in, .mst_rd_valid_out, .mst_rd_data_out, .db_wr_out,
    .db_rd_addr_out, .hw_handshake_enable_in, .clear_to_send_in, .request_to_send_out,
    .blk_rd_req_in, .blk_word_idx_in, .blk_valid_out, .blk_word_out, .ack_valid_in,
    .ack_word0_in, .ack_taken_out);
  ptq_host_model i_ptq_host_model (.clk_in, .blk_word_in(blk_word_out),
    .ack_taken_in(ack_taken_out), .blk_rd_req_out(blk_rd_req_in),
    .blk_word_idx_out(blk_word_idx_in), .ack_valid_out(ack_valid_in),
    .ack_word0_out(ack_word0_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
    i_ptq_host_model.rd(idx, w);
    chk(w, exp);
  endtask
  task automatic send(input logic [7:0] f);
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_in.func = f;
    for (int k = 0; k < 17; k++)
      cmd_in.args[k] = 16'h0100 + 16'(k);
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
    cmd_in = ~cmd_in;
  endtask
  task automatic t_blocks;
    for (int i = 0; i < 4; i++)
    begin
      send(fn_tab[i]);
      chk(16'(blk_valid_out), 16'h0001);
      rdchk(8'h00, 16'h0000);
      rdchk(8'h01, `PTQ_ID_DOUT + 16'(i));
      rdchk(8'(`PTQ_LAST_WORD), `PTQ_ID_DOUT + 16'(i));
      rdchk(8'h02, 16'h0100);
      rdchk(8'(last_tab[i]), 16'h0100 + 16'(last_tab[i] - 2));
      rdchk(8'(last_tab[i] + 1), 16'h0000);
      i_ptq_host_model.ack(`PTQ_ID_DOUT + 16'(i), t);
      chk(16'({t, blk_valid_out}), 16'h0002);
    end
    $display("test blocks done");
  endtask
  task automatic t_order;
    send(8'h03);
    chk(16'(blk_valid_out), 16'h0000);
    send(`PTQ_FN_DOUT);
    send(`PTQ_FN_TIME);
    i_ptq_host_model.ack(`PTQ_ID_TIME, t);
    chk(16'(t), 16'h0000);
    rdchk(8'h01, `PTQ_ID_DOUT);
    i_ptq_host_model.ack(`PTQ_ID_DOUT, t);
    chk(16'(t), 16'h0001);
    rdchk(8'h01, `PTQ_ID_TIME);
    i_ptq_host_model.ack(`PTQ_ID_TIME, t);
    chk(16'({t, blk_valid_out}), 16'h0002);
    i_ptq_host_model.ack(`PTQ_ID_TIME, t);
    chk(16'(t), 16'h0000);
    $display("test order done");
  endtask
  task automatic t_full;
    repeat (4) send(`PTQ_FN_DOUT);
    chk(16'(cmd_ready_out), 16'h0000);
    send(`PTQ_FN_PULSE);
    for (int i = 0; i < 4; i++)
    begin
      rdchk(8'h01, `PTQ_ID_DOUT);
      i_ptq_host_model.ack(`PTQ_ID_DOUT, t);
      chk(16'(t), 16'h0001);
    end
    chk(16'({cmd_ready_out, blk_valid_out}), 16'h0002);
    $display("test full done");
  endtask
  task automatic rdm(input logic en, input logic cts, input logic exp);
    @(posedge clk_in);
    #1;
    hw_handshake_enable_in = en;
    clear_to_send_in = cts;
    mst_rd_valid_in = 1'b1;
    mst_rd_addr_in = 16'h0123;
    db_rd_data_in = 16'h5a5a;
    #1;
    chk(db_rd_addr_out, 16'h0123);
    chk(16'(request_to_send_out), 16'(en));
    @(posedge clk_in);
    #1;
    mst_rd_valid_in = 1'b0;
    db_rd_data_in = 16'ha5a5;
    chk(16'(mst_rd_valid_out), 16'(exp));
    if (exp)
      chk(mst_rd_data_out, 16'h5a5a);
  endtask
  task automatic t_master;
    @(posedge clk_in);
    #1;
    mst_wr_valid_in = 1'b1;
    mst_wr_in = '{1'b1, 16'h0040, 16'hbeef};
    @(posedge clk_in);
    #1;
    mst_wr_valid_in = 1'b0;
    mst_wr_in = ~mst_wr_in;
    chk(16'(db_wr_out.write), 16'h0001);
    chk(db_wr_out.addr, 16'h0040);
    chk(db_wr_out.data, 16'hbeef);
    @(posedge clk_in);
    #1;
    chk(16'(db_wr_out.write), 16'h0000);
    rdm(1'b0, 1'b0, 1'b1);
    rdm(1'b1, 1'b0, 1'b0);
    rdm(1'b1, 1'b1, 1'b1);
    $display("test master done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    t_blocks;
    t_order;
    t_full;
    t_master;
    results;
  end
  initial
  begin
    #100000;
    n_fail++;
    results;
  end
endmodule
